// ### rtl/csor_alu.sv
// Eight-bit ALU with zero, nibble-carry and carry flag generation
`timescale 1ns/10ps
module csor_alu (
	input wire csor_pkg::csor_op_t op, // Operation
	input wire logic [7:0] acc, // Accumulator operand
	input wire logic [7:0] opnd, // File or literal operand
	input wire logic [2:0] bitSel, // Bit for set or clear
	input wire logic carryIn, // Present carry flag
	output logic [7:0] result, // Result byte
	output logic zeroF, // New zero flag
	output logic nibF, // New nibble carry flag
	output logic carryF, // New carry flag
	output logic updZ, // Zero flag affected
	output logic updDc, // Nibble carry affected
	output logic updC // Carry affected
);
	import csor_pkg::*;

	always_comb begin
		logic [7:0] addend;
		logic cin;
		logic [8:0] sum;
		logic [4:0] nib;
		addend = acc;
		cin = 1'b0;
		// Subtract adds the two's complement of the accumulator
		if (op == OP_SUB) begin
			addend = ~acc;
			cin = 1'b1;
		end
		sum = {1'b0, opnd} + {1'b0, addend} + {8'h00, cin};
		nib = {1'b0, opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		result = opnd;
		nibF = 1'b0;
		carryF = carryIn;
		updZ = 1'b0;
		updDc = 1'b0;
		updC = 1'b0;
		case (op)
			OP_ADD, OP_SUB: begin
				result = sum[7:0];
				nibF = nib[4];
				carryF = sum[8];
				updZ = 1'b1;
				updDc = 1'b1;
				updC = 1'b1;
			end
			OP_AND: begin
				result = acc & opnd;
				updZ = 1'b1;
			end
			OP_IOR: begin
				result = acc | opnd;
				updZ = 1'b1;
			end
			OP_XOR: begin
				result = acc ^ opnd;
				updZ = 1'b1;
			end
			OP_COM: begin
				result = ~opnd;
				updZ = 1'b1;
			end
			OP_INC: begin
				result = opnd + 8'h01;
				updZ = 1'b1;
			end
			OP_DEC: begin
				result = opnd - 8'h01;
				updZ = 1'b1;
			end
			OP_RLF: begin
				result = {opnd[6:0], carryIn};
				carryF = opnd[7];
				updC = 1'b1;
			end
			OP_RRF: begin
				result = {carryIn, opnd[7:1]};
				carryF = opnd[0];
				updC = 1'b1;
			end
			OP_SWAP: result = {opnd[3:0], opnd[7:4]};
			OP_MOV: updZ = 1'b1;
			OP_MOVW: result = acc;
			OP_CLR: begin
				result = 8'h00;
				updZ = 1'b1;
			end
			OP_BCF: result = opnd & ~(8'h01 << bitSel);
			OP_BSF: result = opnd | (8'h01 << bitSel);
			default: result = opnd;
		endcase
		zeroF = (result == 8'h00);
	end

endmodule

// ### rtl/csor_core.sv
// Status, option and peripheral flag registers with ALU execute stage
//
// Functional notes
// - Flag ops writing status keep flag results
// - Software writes never change timeout/power-down
// - Bit 7 picks indirect bank pair
// - Bits 6-5 pick 128-byte direct bank
// - Zero flag set on zero result
// - Nibble carry from bit 3, inverted for borrow
// - Carry from bit 7, inverted for borrow
// - Subtract adds two's complement of accumulator
// - Rotates load carry from shifted-out bit
// - Clearing status gives 000u u1uu
// - Eight-bit two's complement ALU
// - Accumulator against file or literal operand
// - Accumulator is not address mapped
// - Option fully read/write, resets to ones
// - Option bit 3 gives prescaler to watchdog
// - Peripheral flags set regardless of enables
// - Two-stage overlap, one instruction per cycle
`timescale 1ns/10ps
module csor_core (
	input wire logic mclk, // System clock, 200 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic powerOnRst, // Reset is a power-up reset
	input wire logic fetchValid, // Fetched instruction present
	input wire csor_pkg::csor_op_t fetchOp, // Fetched operation
	input wire logic fetchUseLit, // Operand is the literal
	input wire logic [7:0] fetchLit, // Literal operand
	input wire logic [6:0] fetchFile, // Direct file address
	input wire logic fetchIndirect, // Address taken from pointer
	input wire logic fetchDestFile, // Result to file, else acc
	input wire logic [2:0] fetchBit, // Bit number for set/clear
	input wire logic flush, // Branch: drop fetched word
	input wire logic [7:0] fsrVal, // Indirect pointer value
	input wire logic [7:0] extRdData, // File memory read data
	input wire logic [7:0] periphEvt, // Peripheral event pulses
	input wire logic wdtTimeoutEvt, // Watchdog expired pulse
	input wire logic tmrTick, // Timer zero source pulse
	input wire logic wdtTick, // Watchdog source pulse
	output logic instrCycle, // Instruction cycle pulse
	output logic [8:0] extAddr, // File address in execute
	output logic extWrEn, // File memory write pulse
	output logic [8:0] extWrAddr, // File memory write address
	output logic [7:0] extWrData, // File memory write data
	output logic [7:0] statusOut, // Status register
	output logic [7:0] optionOut, // Option register
	output logic [7:0] pirOut, // Peripheral flag register
	output logic [7:0] accOut, // Accumulator view
	output logic tmrInc, // Timer zero increment pulse
	output logic wdtInc // Watchdog increment pulse
);
	import csor_pkg::*;

	localparam logic [5:0] CYC_LAST = 6'(ICYC_CLKS - 1);

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] option;
		logic [7:0] pir;
		logic [7:0] acc;
		logic [5:0] cycCnt;
		logic exV;
		csor_op_t exOp;
		logic exUseLit;
		logic [7:0] exLit;
		logic [6:0] exFile;
		logic exIndirect;
		logic exDestFile;
		logic [2:0] exBit;
		logic wrEn;
		logic [8:0] wrAddr;
		logic [7:0] wrData;
	} csor_core_t;

	csor_core_t s;
	csor_core_t next_s;

	logic cycTick;
	logic exec;
	logic writeFile;
	logic flagOp;
	csor_sfr_t sfr;
	logic [7:0] operand;
	logic [7:0] aluRes;
	logic aluZ;
	logic aluDc;
	logic aluC;
	logic updZ;
	logic updDc;
	logic updC;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Status is mirrored in every bank, option in banks 1 and 3
	function automatic csor_sfr_t sfrOf(input logic [8:0] a);
		if (a[6:0] == STATUS_OFS[6:0]) begin
			sfrOf = SFR_STATUS;
		end else if (a[7] && a[6:0] == OPTION_OFS[6:0]) begin
			sfrOf = SFR_OPTION;
		end else if (a == PIR_OFS) begin
			sfrOf = SFR_PIR;
		end else begin
			sfrOf = SFR_NONE;
		end
	endfunction

	always_comb begin
		if (s.exIndirect) begin
			extAddr = {s.status[ST_IRP], fsrVal};
		end else begin
			extAddr = {s.status[ST_RPHI:ST_RPLO], s.exFile};
		end
	end

	assign sfr = sfrOf(extAddr);
	assign cycTick = (s.cycCnt == CYC_LAST);
	assign exec = s.exV && cycTick;

	// Accumulator has no address; it only feeds the ALU directly
	always_comb begin
		if (s.exUseLit) begin
			operand = s.exLit;
		end else if (sfr == SFR_STATUS) begin
			operand = s.status;
		end else if (sfr == SFR_OPTION) begin
			operand = s.option;
		end else if (sfr == SFR_PIR) begin
			operand = s.pir;
		end else begin
			operand = extRdData;
		end
	end

	csor_alu i_csor_alu (
		.op(s.exOp),
		.acc(s.acc),
		.opnd(operand),
		.bitSel(s.exBit),
		.carryIn(s.status[ST_C]),
		.result(aluRes),
		.zeroF(aluZ),
		.nibF(aluDc),
		.carryF(aluC),
		.updZ(updZ),
		.updDc(updDc),
		.updC(updC)
	);

	assign flagOp = updZ || updDc || updC;
	assign writeFile = exec && s.exDestFile && !s.exUseLit &&
		s.exOp != OP_NOP && s.exOp != OP_SLEEP && s.exOp != OP_CLRWDT &&
		s.exOp != OP_LIT;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.wrEn = 1'b0;
		next_s.cycCnt = cycTick ? 6'h00 : s.cycCnt + 6'h01;
		// Fetch of the next word overlaps execution of this one
		if (cycTick) begin
			next_s.exV = fetchValid && !flush;
			next_s.exOp = fetchOp;
			next_s.exUseLit = fetchUseLit;
			next_s.exLit = fetchLit;
			next_s.exFile = fetchFile;
			next_s.exIndirect = fetchIndirect;
			next_s.exDestFile = fetchDestFile;
			next_s.exBit = fetchBit;
		end
		if (exec && !s.exDestFile && s.exOp != OP_NOP &&
			s.exOp != OP_SLEEP && s.exOp != OP_CLRWDT) begin
			next_s.acc = aluRes;
		end
		if (writeFile && sfr == SFR_STATUS) begin
			next_s.status[ST_IRP:ST_RPLO] = aluRes[ST_IRP:ST_RPLO];
			if (!flagOp) begin
				next_s.status[ST_Z:ST_C] = aluRes[ST_Z:ST_C];
			end
		end
		// Flag logic overrides any data write to the same bits
		if (exec && updZ) begin
			next_s.status[ST_Z] = aluZ;
		end
		if (exec && updDc) begin
			next_s.status[ST_DC] = aluDc;
		end
		if (exec && updC) begin
			next_s.status[ST_C] = aluC;
		end
		// Apart from power-up reset, time-out and power-down move only on these events
		if (exec && s.exOp == OP_SLEEP) begin
			next_s.status[ST_TO] = 1'b1;
			next_s.status[ST_PD] = 1'b0;
		end
		if (exec && s.exOp == OP_CLRWDT) begin
			next_s.status[ST_TO] = 1'b1;
			next_s.status[ST_PD] = 1'b1;
		end
		if (wdtTimeoutEvt) begin
			next_s.status[ST_TO] = 1'b0;
		end
		if (writeFile && sfr == SFR_OPTION) begin
			next_s.option = aluRes;
		end
		if (writeFile && sfr == SFR_PIR) begin
			next_s.pir = aluRes;
		end
		// Event in the clearing cycle still lands: set wins
		next_s.pir = next_s.pir | periphEvt;
		if (writeFile && sfr == SFR_NONE) begin
			next_s.wrEn = 1'b1;
			next_s.wrAddr = extAddr;
			next_s.wrData = aluRes;
		end
		if (sys_rst) begin
			next_s.cycCnt = 6'h00;
			next_s.exV = 1'b0;
			next_s.wrEn = 1'b0;
			next_s.option = OPT_RST;
			next_s.pir = PIR_RST;
			next_s.status[ST_IRP:ST_RPLO] = ST_BANK_RST;
			// Only a power-up defines the read-only and ALU flags
			if (powerOnRst) begin
				next_s.status[ST_TO:ST_PD] = ST_TOPD_RST;
				next_s.status[ST_Z:ST_C] = ST_FLAG_RST;
				next_s.acc = 8'h00;
				next_s.exOp = OP_NOP;
				next_s.wrAddr = 9'h000;
				next_s.wrData = 8'h00;
			end
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	assign instrCycle = cycTick;
	assign extWrEn = s.wrEn;
	assign extWrAddr = s.wrAddr;
	assign extWrData = s.wrData;
	assign statusOut = s.status;
	assign optionOut = s.option;
	assign pirOut = s.pir;
	assign accOut = s.acc;

	csor_prescaler i_csor_prescaler (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.prescaler_assign(s.option[OPT_PSA]),
		.rateSel(s.option[OPT_PS_HI:0]),
		.tmrTick(tmrTick),
		.wdtTick(wdtTick),
		.tmrInc(tmrInc),
		.wdtInc(wdtInc)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence capture_s;
		cycTick && fetchValid && !flush;
	endsequence
	sequence execute_s;
		s.exV ##39 exec;
	endsequence

	a_pipe_overlap: assert property (capture_s |=> execute_s)
		else $error("fetched instruction did not execute next cycle");
	a_flag_block: assert property (
		exec && s.exDestFile && sfr == SFR_STATUS && updZ && !s.exUseLit
		|=> statusOut[ST_Z] == $past(aluZ))
		else $error("data write reached a flag bit");
	a_ro_flags: assert property (
		writeFile && sfr == SFR_STATUS && !wdtTimeoutEvt
		|=> statusOut[ST_TO:ST_PD] == $past(statusOut[ST_TO:ST_PD]))
		else $error("software changed read-only flags");
	a_bank_direct: assert property (
		s.exV && !s.exIndirect
		|-> extAddr[8:7] == statusOut[ST_RPHI:ST_RPLO])
		else $error("direct bank select wrong");
	a_bank_indirect: assert property (
		s.exV && s.exIndirect |-> extAddr[8] == statusOut[ST_IRP])
		else $error("indirect bank select wrong");
	a_zero_flag: assert property (
		exec && updZ |=> statusOut[ST_Z] == ($past(aluRes) == 8'h00))
		else $error("zero flag wrong");
	a_sub_borrow: assert property (
		exec && s.exOp == OP_SUB |=>
		statusOut[ST_C] == ($past(operand) >= $past(s.acc)) &&
		statusOut[ST_DC] == ($past(operand[3:0]) >= $past(s.acc[3:0])))
		else $error("borrow polarity wrong");
	a_add_nibble: assert property (
		exec && s.exOp == OP_ADD |=> statusOut[ST_DC] ==
		(({1'b0, $past(operand[3:0])} + {1'b0, $past(s.acc[3:0])}) > 5'hF))
		else $error("nibble carry wrong on add");
	a_rotate_carry: assert property (
		exec && s.exOp == OP_RLF |=> statusOut[ST_C] == $past(operand[7]))
		else $error("rotate left carry wrong");
	a_clr_status: assert property (
		exec && s.exOp == OP_CLR && s.exDestFile && sfr == SFR_STATUS
		|=> statusOut[7:5] == 3'h0 && statusOut[ST_Z] &&
		statusOut[ST_DC:ST_C] == $past(statusOut[ST_DC:ST_C]))
		else $error("status clear result wrong");
	a_opt_reset: assert property (@(posedge mclk)
		disable iff (1'b0) sys_rst |=> optionOut == OPT_RST)
		else $error("option reset value wrong");
	a_por_status: assert property (@(posedge mclk)
		disable iff (1'b0) sys_rst && powerOnRst |=> statusOut[7:3] == 5'h03)
		else $error("power-on status value wrong");
	a_pir_set: assert property (
		|periphEvt |=> (pirOut & $past(periphEvt)) == $past(periphEvt))
		else $error("peripheral flag lost");
	a_wdt_timeout: assert property (
		wdtTimeoutEvt |=> !statusOut[ST_TO] ##1 (!statusOut[ST_TO] ||
		$past(exec)))
		else $error("timeout flag not cleared");
	a_sleep_flags: assert property (
		exec && s.exOp == OP_SLEEP && !wdtTimeoutEvt
		|=> statusOut[ST_TO] && !statusOut[ST_PD])
		else $error("sleep flags wrong");

endmodule

// ### rtl/csor_pkg.sv
// Constants, field layout and types of the core status and option logic
package csor_pkg;

	// ----------------------------------------
	// Register offsets (full 9-bit data address)
	// ----------------------------------------
	localparam logic [8:0] STATUS_OFS = 9'h003;
	localparam logic [8:0] PIR_OFS = 9'h00C;
	localparam logic [8:0] OPTION_OFS = 9'h081;
	localparam int BANK_BYTES = 128;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ST_IRP = 7;
	localparam int ST_RPHI = 6;
	localparam int ST_RPLO = 5;
	localparam int ST_TO = 4;
	localparam int ST_PD = 3;
	localparam int ST_Z = 2;
	localparam int ST_DC = 1;
	localparam int ST_C = 0;
	localparam int OPT_PSA = 3;
	localparam int OPT_PS_HI = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [2:0] ST_BANK_RST = 3'h0;
	localparam logic [1:0] ST_TOPD_RST = 2'h3;
	localparam logic [2:0] ST_FLAG_RST = 3'h0;
	localparam logic [7:0] OPT_RST = 8'hFF;
	localparam logic [7:0] PIR_RST = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 5;
	localparam int ICYC_NS = 200;
	localparam int ICYC_CLKS = ICYC_NS / CLK_NS;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_COM, OP_INC,
		OP_DEC, OP_RLF, OP_RRF, OP_SWAP, OP_MOV, OP_MOVW, OP_CLR, OP_BCF,
		OP_BSF, OP_LIT, OP_SLEEP, OP_CLRWDT
	} csor_op_t;

	typedef enum logic [1:0] {
		SFR_NONE, SFR_STATUS, SFR_OPTION, SFR_PIR
	} csor_sfr_t;

endpackage

// ### rtl/csor_prescaler.sv
// Shared timer-zero / watchdog prescaler with assignment and rate select
`timescale 1ns/10ps
module csor_prescaler (
	input wire logic mclk, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic prescaler_assign, // Prescaler on watchdog when high
	input wire logic [2:0] rateSel, // Prescale rate field
	input wire logic tmrTick, // Timer zero source pulse
	input wire logic wdtTick, // Watchdog source pulse
	output logic tmrInc, // Timer zero increment pulse
	output logic wdtInc // Watchdog increment pulse
);
	import csor_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic psaLast;
		logic tmrInc;
		logic wdtInc;
	} csor_pre_t;

	csor_pre_t s;
	csor_pre_t next_s;

	function automatic logic [7:0] lowMask(input logic [3:0] e);
		lowMask = 8'(9'h1FF >> (4'h9 - e));
	endfunction

	always_comb begin
		logic src;
		logic [3:0] expo;
		logic hit;
		next_s = s;
		src = prescaler_assign ? wdtTick : tmrTick;
		// Watchdog divides by 2^n, timer zero by 2^(n+1)
		expo = prescaler_assign ? {1'b0, rateSel} : {1'b0, rateSel} + 4'h1;
		hit = src && ((s.cnt & lowMask(expo)) == lowMask(expo));
		// Reassignment restarts the count so no stale half-period leaks
		if (prescaler_assign != s.psaLast) begin
			next_s.cnt = 8'h00;
		end else if (src) begin
			next_s.cnt = s.cnt + 8'h01;
		end
		next_s.psaLast = prescaler_assign;
		next_s.tmrInc = prescaler_assign ? tmrTick : hit;
		next_s.wdtInc = prescaler_assign ? hit : wdtTick;
		if (sys_rst) begin
			next_s = '0;
			next_s.psaLast = OPT_RST[OPT_PSA];
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	assign tmrInc = s.tmrInc;
	assign wdtInc = s.wdtInc;

	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_tmr_bypass: assert property (prescaler_assign && $stable(prescaler_assign) && tmrTick |=> tmrInc)
		else $error("timer zero not 1:1 with prescaler on watchdog");
	a_wdt_unity: assert property (
		prescaler_assign && $stable(prescaler_assign) && rateSel == 3'h0 && wdtTick |=> wdtInc)
		else $error("watchdog rate 1:1 not passed through");
	a_tmr_half: assert property (
		!prescaler_assign && $stable(prescaler_assign) && rateSel == 3'h0 && tmrTick && !s.cnt[0]
		|=> !tmrInc)
		else $error("timer zero prescale 1:2 fired early");

endmodule

// ### sim/csor_core_bench.sv
// Self-checking bench for the core status, option and peripheral flags
`timescale 1ns/10ps
module csor_core_bench;
	import csor_pkg::*;

	logic mclk, sysRst, powerOnRst, fetchValid, fetchUseLit;
	csor_op_t fetchOp;
	logic [7:0] fetchLit, fsrVal, extRdData, periphEvt;
	logic [6:0] fetchFile;
	logic fetchIndirect, fetchDestFile, flush, wdtTimeoutEvt;
	logic [2:0] fetchBit;
	logic tmrTick, wdtTick, instrCycle, extWrEn, tmrInc, wdtInc;
	logic [8:0] extAddr, extWrAddr;
	logic [7:0] extWrData, statusOut, optionOut, pirOut, accOut;
	logic [7:0] expSt;
	int fails, checks, tmrCnt, wdtCnt, wrCnt;

	csor_core i_csor_core (.mclk(mclk), .sys_rst(sysRst),
		.powerOnRst(powerOnRst), .fetchValid(fetchValid),
		.fetchOp(fetchOp), .fetchUseLit(fetchUseLit), .fetchLit(fetchLit),
		.fetchFile(fetchFile), .fetchIndirect(fetchIndirect),
		.fetchDestFile(fetchDestFile), .fetchBit(fetchBit), .flush(flush),
		.fsrVal(fsrVal), .extRdData(extRdData), .periphEvt(periphEvt),
		.wdtTimeoutEvt(wdtTimeoutEvt), .tmrTick(tmrTick), .wdtTick(wdtTick),
		.instrCycle(instrCycle), .extAddr(extAddr), .extWrEn(extWrEn),
		.extWrAddr(extWrAddr), .extWrData(extWrData),
		.statusOut(statusOut), .optionOut(optionOut), .pirOut(pirOut),
		.accOut(accOut), .tmrInc(tmrInc), .wdtInc(wdtInc));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// ----------------------------------------
	// Output pulse counters
	// ----------------------------------------
	always @(posedge mclk) begin
		if (tmrInc === 1'b1)
			tmrCnt = tmrCnt + 1;
		if (wdtInc === 1'b1)
			wdtCnt = wdtCnt + 1;
		if (extWrEn === 1'b1 && extWrAddr === 9'h020 && extWrData === 8'h5A)
			wrCnt = wrCnt + 1;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk8(input string what, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic chk9(input string what, input logic [8:0] e,
		input logic [8:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	// Present a word and return just after the edge that captures it
	task automatic issue(input csor_op_t op, input logic [7:0] lit,
		input logic useLit, input logic [6:0] file, input logic dest,
		input logic [7:0] rd);
		int n;
		@(posedge mclk);
		fetchOp <= op;
		fetchLit <= lit;
		fetchUseLit <= useLit;
		fetchFile <= file;
		fetchDestFile <= dest;
		fetchValid <= 1'b1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (instrCycle !== 1'b1 && n < 100);
		chk8("cycle found", 8'h01, {7'h00, n < 100});
		@(posedge mclk);
		extRdData <= rd;
	endtask

	// A trailing no-op pushes the previous word through execute
	task automatic settle;
		issue(OP_NOP, 8'h00, 1'b0, 7'h00, 1'b0, 8'h00);
		@(negedge mclk);
		@(negedge mclk);
	endtask

	task automatic wr(input logic [6:0] file, input logic [7:0] v);
		issue(OP_LIT, v, 1'b1, 7'h00, 1'b0, 8'h00);
		issue(OP_MOVW, 8'h00, 1'b0, file, 1'b1, 8'h00);
		settle();
	endtask

	task automatic sb(input logic [7:0] v);
		wr(7'h03, v);
		expSt = {v[7:5], expSt[4:3], v[2:0]};
		chk8("status", expSt, statusOut);
	endtask

	task automatic arith(input csor_op_t op, input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] h;
		issue(OP_LIT, a, 1'b1, 7'h00, 1'b0, 8'h00);
		issue(op, b, 1'b1, 7'h00, 1'b0, 8'h00);
		settle();
		if (op == OP_ADD) begin
			s = {1'b0, a} + {1'b0, b};
			h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		end else begin
			s = {1'b0, b} + {1'b0, ~a} + 9'h001;
			h = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
		end
		expSt[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
		chk8("acc", s[7:0], accOut);
		chk8("status", expSt, statusOut);
	endtask

	// 256 ticks a call bring the prescale counter back to where it began
	task automatic opt(input logic [7:0] v);
		int t;
		int w;
		wr(7'h01, v);
		chk8("option", v, optionOut);
		tmrCnt = 0;
		wdtCnt = 0;
		repeat (256) begin
			@(posedge mclk);
			tmrTick <= 1'b1;
			wdtTick <= 1'b1;
			@(posedge mclk);
			tmrTick <= 1'b0;
			wdtTick <= 1'b0;
		end
		repeat (4) @(negedge mclk);
		t = v[3] ? 256 : 256 >> (v[2:0] + 1);
		w = v[3] ? 256 >> v[2:0] : 256;
		chk9("timer incs", t[8:0], tmrCnt[8:0]);
		chk9("wdog incs", w[8:0], wdtCnt[8:0]);
	endtask

	task automatic rst(input logic por);
		@(posedge mclk);
		sysRst <= 1'b1;
		powerOnRst <= por;
		repeat (6) @(posedge mclk);
		sysRst <= 1'b0;
		powerOnRst <= 1'b0;
	endtask

	task automatic complete_run;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		fails++;
		$display("ERROR watchdog expected finish seen timeout");
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{sysRst, powerOnRst} = 2'b11;
		{fetchValid, fetchUseLit, fetchIndirect, fetchDestFile} = 4'h0;
		fetchOp = OP_NOP;
		{fetchLit, fsrVal, extRdData, periphEvt} = 32'h0;
		{fetchFile, fetchBit, flush} = 11'h000;
		{wdtTimeoutEvt, tmrTick, wdtTick} = 3'h0;
		{fails, checks, tmrCnt, wdtCnt, wrCnt} = 160'h0;
		repeat (6) @(posedge mclk);
		sysRst <= 1'b0;
		powerOnRst <= 1'b0;
		expSt = 8'h18;
		@(negedge mclk);
		chk8("status", expSt, statusOut);
		chk8("option", 8'hFF, optionOut);
		chk8("pir", 8'h00, pirOut);
		arith(OP_ADD, 8'h0F, 8'h01);
		arith(OP_ADD, 8'hF0, 8'h10);
		arith(OP_ADD, 8'h88, 8'h88);
		arith(OP_SUB, 8'h05, 8'h05);
		arith(OP_SUB, 8'h01, 8'h10);
		arith(OP_SUB, 8'h01, 8'h00);
		// Dropped word leaves the accumulator alone
		@(posedge mclk);
		flush <= 1'b1;
		issue(OP_LIT, 8'h33, 1'b1, 7'h00, 1'b0, 8'h00);
		flush <= 1'b0;
		settle();
		chk8("acc", 8'hFF, accOut);
		issue(OP_RLF, 8'h00, 1'b0, 7'h20, 1'b0, 8'h81);
		settle();
		chk8("acc", {7'h01, expSt[0]}, accOut);
		expSt[0] = 1'b1;
		chk8("status", expSt, statusOut);
		issue(OP_RRF, 8'h00, 1'b0, 7'h20, 1'b0, 8'h02);
		settle();
		chk8("acc", 8'h81, accOut);
		expSt[0] = 1'b0;
		chk8("status", expSt, statusOut);
		@(posedge mclk);
		fetchBit <= 3'h0;
		issue(OP_BSF, 8'h00, 1'b0, 7'h03, 1'b1, 8'h00);
		settle();
		expSt[0] = 1'b1;
		chk8("status", expSt, statusOut);
		for (int i = 0; i < 4; i++) begin
			sb({i[0], i[1:0], 5'h00});
			issue(OP_LIT, 8'h5A, 1'b1, 7'h00, 1'b0, 8'h00);
			issue(OP_MOVW, 8'h00, 1'b0, 7'h20, 1'b1, 8'h00);
			@(negedge mclk);
			chk9("direct addr", {i[1:0], 7'h20}, extAddr);
			@(posedge mclk);
			fetchIndirect <= 1'b1;
			fsrVal <= 8'h45;
			issue(OP_MOVW, 8'h00, 1'b0, 7'h00, 1'b1, 8'h00);
			fetchIndirect <= 1'b0;
			@(negedge mclk);
			chk9("indirect addr", {i[0], 8'h45}, extAddr);
			settle();
		end
		chk9("bank0 writes", 9'h001, wrCnt[8:0]);
		sb(8'h20);
		opt(8'h00);
		opt(8'hCA);
		opt(8'h37);
		opt(8'h0F);
		opt(8'h08);
		sb(8'hE7);
		issue(OP_CLR, 8'h00, 1'b0, 7'h03, 1'b1, 8'h00);
		settle();
		expSt = {3'h0, expSt[4:3], 1'b1, expSt[1:0]};
		chk8("status", expSt, statusOut);
		@(posedge mclk);
		periphEvt <= 8'hA5;
		@(posedge mclk);
		periphEvt <= 8'h00;
		@(negedge mclk);
		chk8("pir", 8'hA5, pirOut);
		wr(7'h0C, 8'h00);
		chk8("pir", 8'h00, pirOut);
		issue(OP_SLEEP, 8'h00, 1'b0, 7'h00, 1'b0, 8'h00);
		settle();
		expSt[4:3] = 2'b10;
		chk8("status", expSt, statusOut);
		issue(OP_CLRWDT, 8'h00, 1'b0, 7'h00, 1'b0, 8'h00);
		settle();
		expSt[4:3] = 2'b11;
		chk8("status", expSt, statusOut);
		sb(8'hE0);
		@(posedge mclk);
		wdtTimeoutEvt <= 1'b1;
		@(posedge mclk);
		wdtTimeoutEvt <= 1'b0;
		@(negedge mclk);
		expSt[4] = 1'b0;
		chk8("status", expSt, statusOut);
		// Warm reset keeps the read-only flags
		rst(1'b0);
		@(negedge mclk);
		expSt[7:5] = 3'h0;
		chk8("status", expSt, statusOut);
		chk8("option", 8'hFF, optionOut);
		complete_run();
	end
endmodule
